// file: src/swc_ctrl.v
// Selective wake control: control register, bit time quanta register, low-power receiver
// option register, calibration unlock and time-out interrupt gating.
// Assumes a byte-wide synchronous register port from the chip's serial interface decoder.
//
// Function
// [RULE1] Selective wake is enabled only while the host has set the configuration-valid bit.
// [RULE2] The valid bit clears itself on a wake event, on reset, or on any wake config change.
// [RULE3] In stop mode any write to a CAN or wake configuration register clears the valid bit.
// [RULE4] Recalibration is unlocked only when the unlock field holds 11.
// [RULE5] The unlock value 11 also gates writes to the low-power receiver option register.
// [RULE6] The calibration mode bit enables oscillator calibration when one.
// [RULE7] During trimming the oscillator synchronises to edges on the transmit data pin.
// [RULE8] The time-out mask bit passes a bus time-out to the interrupt only when one.
// [RULE9] The time-out flag updates only while the wake-enabled transceiver mode is set.
// [RULE10] Bits 3:1 of the control register always read as zero.
// [RULE11] The control register resets to zero and a restart clears only its low nibble.
// [RULE12] The quanta register gives time quanta per bit, the decoder's nominal bit length.
// [RULE13] The quantum duration follows the oscillator clock select field.
// [RULE14] The quanta register resets to a0 and keeps its value across a restart.
// [RULE15] Without the unlock code calibration stays disabled regardless of the mode bit.
`include "swc_consts.vh"
`default_nettype none

module swc_ctrl (
    input  wire                   clk,
    input  wire                   reset,
    input  wire                   restart,
    input  wire [`SWC_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire                   stop_mode,
    input  wire                   wake_event,
    input  wire                   wake_cfg_write,
    input  wire                   transceiver_wake_mode,
    input  wire                   bus_timeout_event,
    input  wire [1:0]             osc_clock_select,
    input  wire                   can_tx_pin,
    output reg  [7:0]             reg_rdata,
    output reg                    selective_wake_enable,
    output reg                    osc_calibration_mode_enable,
    output reg                    osc_sync_pulse,
    output reg                    bus_timeout_flag,
    output reg                    bus_timeout_irq,
    output reg  [7:0]             quanta_per_bit,
    output reg  [1:0]             quantum_clock_select,
    output reg  [7:0]             low_power_rx_option
);
    reg  [7:0] ctrl_reg;
    reg  [7:0] ctrl_next;
    reg  [7:0] quanta_reg;
    reg  [7:0] opt_reg;
    wire       unlocked;
    wire       edge_pulse;
    wire       wr_ctrl;
    wire       wr_quanta;
    wire       wr_opt;
    wire       cfg_changed;

    // Any address of the CAN / wake configuration space counts as configuration data.
    function is_wake_cfg;
        input [`SWC_ADDR_W-1:0] a;
        begin
            is_wake_cfg = (a >= `SWC_ADDR_CTRL) && (a <= `SWC_ADDR_OPT);
        end
    endfunction

    assign unlocked  = (ctrl_reg[`SWC_BIT_UNLOCK_HI:`SWC_BIT_UNLOCK_LO]
                       == `SWC_UNLOCK_CODE); // [RULE4]
    assign wr_ctrl   = reg_wr & (reg_addr == `SWC_ADDR_CTRL);
    assign wr_quanta = reg_wr & (reg_addr == `SWC_ADDR_QUANTA);
    assign wr_opt    = reg_wr & (reg_addr == `SWC_ADDR_OPT) & unlocked; // [RULE5]
    // A write to the control register itself is not a change of the wake setup data.
    assign cfg_changed = wake_cfg_write | (reg_wr & is_wake_cfg(reg_addr) & ~wr_ctrl);

    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = reg_wdata & `SWC_CTRL_WMASK; // [RULE10]
        end
        // Clears are applied after the host write, so a self-clear always wins over a set.
        if (wake_event | cfg_changed) begin
            ctrl_next[`SWC_BIT_CFG_VALID] = 1'b0; // [RULE2]
        end
        if (stop_mode & reg_wr & is_wake_cfg(reg_addr)) begin
            ctrl_next[`SWC_BIT_CFG_VALID] = 1'b0; // [RULE3]
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            ctrl_reg   <= `SWC_CTRL_RESET; // [RULE11]
            quanta_reg <= `SWC_QUANTA_RESET; // [RULE14]
            opt_reg    <= `SWC_OPT_RESET;
        end else if (restart) begin
            ctrl_reg   <= ctrl_reg & `SWC_CTRL_UPPER; // [RULE11]
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr_quanta) begin
                quanta_reg <= reg_wdata;
            end
            if (wr_opt) begin
                opt_reg <= reg_wdata;
            end
        end
    end

    swc_sync_detect u_sync (
        .clk        (clk),
        .reset      (reset),
        .enable     (osc_calibration_mode_enable),
        .pin        (can_tx_pin),
        .edge_pulse (edge_pulse)
    );

    always @(posedge clk) begin
        if (reset) begin
            reg_rdata             <= 8'h00;
            selective_wake_enable <= 1'b0;
            osc_calibration_mode_enable        <= 1'b0;
            osc_sync_pulse        <= 1'b0;
            bus_timeout_flag      <= 1'b0;
            bus_timeout_irq       <= 1'b0;
            quanta_per_bit        <= `SWC_QUANTA_RESET;
            quantum_clock_select  <= `SWC_CLKSEL_RESET;
            low_power_rx_option   <= `SWC_OPT_RESET;
        end else begin
            selective_wake_enable <= ctrl_reg[`SWC_BIT_CFG_VALID]; // [RULE1]
            osc_calibration_mode_enable <= ctrl_reg[`SWC_BIT_CAL_MODE] & unlocked; // [RULE6] [RULE15]
            osc_sync_pulse <= edge_pulse; // [RULE7]
            if (transceiver_wake_mode) begin
                bus_timeout_flag <= bus_timeout_event; // [RULE9]
            end
            bus_timeout_irq <= transceiver_wake_mode & bus_timeout_event
                               & ctrl_reg[`SWC_BIT_TO_MASK]; // [RULE8]
            quanta_per_bit       <= quanta_reg; // [RULE12]
            quantum_clock_select <= osc_clock_select; // [RULE13]
            low_power_rx_option  <= opt_reg;
            if (reg_rd) begin
                case (reg_addr)
                    `SWC_ADDR_CTRL:   reg_rdata <= ctrl_reg;
                    `SWC_ADDR_QUANTA: reg_rdata <= quanta_reg;
                    `SWC_ADDR_OPT:    reg_rdata <= opt_reg;
                    default:          reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // swc_ctrl

`default_nettype wire

// file: src/swc_consts.vh
// Constants for the selective wake control block: register addresses, field positions,
// reset values and register write masks.
// Assumes inclusion by bare name from the design files under src/.
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH

`define SWC_ADDR_W            7
`define SWC_ADDR_CTRL         7'h20
`define SWC_ADDR_QUANTA       7'h21
`define SWC_ADDR_OPT          7'h2f
`define SWC_BIT_CFG_VALID     0
`define SWC_BIT_TO_MASK       4
`define SWC_BIT_UNLOCK_LO     5
`define SWC_BIT_UNLOCK_HI     6
`define SWC_BIT_CAL_MODE      7
`define SWC_CTRL_WMASK        8'hf1
`define SWC_CTRL_RESET        8'h00
`define SWC_CTRL_UPPER        8'hf0
`define SWC_QUANTA_RESET      8'ha0
`define SWC_OPT_RESET         8'h00
`define SWC_UNLOCK_CODE       2'h3
`define SWC_CLKSEL_RESET      2'h0

`endif

// file: src/swc_sync_detect.v
// Edge detector for the transmit data pin used as calibration reference.
// Assumes the pin is already synchronous to clk.
`default_nettype none

module swc_sync_detect (
    input  wire       clk,
    input  wire       reset,
    input  wire       enable,
    input  wire       pin,
    output reg        edge_pulse
);
    reg pin_reg;

    always @(posedge clk) begin
        if (reset) begin
            pin_reg    <= 1'b1;
            edge_pulse <= 1'b0;
        end else begin
            pin_reg    <= pin;
            edge_pulse <= enable & (pin ^ pin_reg);
        end
    end
endmodule // swc_sync_detect

`default_nettype wire

// file: verif/swc_chk_sva.sv
// Port checker for swc_ctrl.
// Assumes it is bound to swc_ctrl and sees only its ports.
`default_nettype none
module swc_chk (
    input wire logic       clk, reset, restart, reg_wr, reg_rd, stop_mode,
    input wire logic       wake_event, transceiver_wake_mode, bus_timeout_event,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata, quanta_per_bit,
    input wire logic       selective_wake_enable, osc_calibration_mode_enable,
    input wire logic       bus_timeout_flag, bus_timeout_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // A restart swallows the write, so it is left out of every write trigger.
    sequence s_wr(a);
        reg_wr && !restart && reg_addr == a;
    endsequence
    AST_EN_SRC: assert property ($rose(selective_wake_enable) |-> $past(reg_wr, 2))
        else $error("wake enable rose without a write");
    AST_WAKE: assert property (wake_event |=> ##1 !selective_wake_enable)
        else $error("wake event left wake enabled");
    AST_STOP: assert property (stop_mode ##0 s_wr(7'h20) |=> ##1 !selective_wake_enable)
        else $error("stop mode write left wake enabled");
    AST_LOCK: assert property (s_wr(7'h20) ##0 reg_wdata[6:5] != 2'h3 |=> ##1 !osc_calibration_mode_enable)
        else $error("calibration on while locked");
    AST_CAL: assert property (s_wr(7'h20) ##0 reg_wdata[7:5] == 3'h7 |=> ##1 osc_calibration_mode_enable)
        else $error("calibration not enabled");
    AST_IRQ: assert property (bus_timeout_irq |-> $past(bus_timeout_event && transceiver_wake_mode))
        else $error("interrupt without time-out");
    AST_FLAG: assert property (!transceiver_wake_mode |=> $stable(bus_timeout_flag))
        else $error("flag moved outside wake mode");
    AST_RSV: assert property (reg_rd && reg_addr == 7'h20 |=> reg_rdata[3:1] == 3'h0)
        else $error("reserved bits read nonzero");
    AST_QUANTA: assert property (s_wr(7'h21) |=> ##1 quanta_per_bit == $past(reg_wdata, 2))
        else $error("quanta copy wrong");
    AST_QRST: assert property (disable iff (1'b0) reset |=> quanta_per_bit == 8'ha0)
        else $error("quanta reset value wrong");
endmodule // swc_chk
`default_nettype wire

// file: verif/swc_peer.sv
// Far-side model driving the transmit data pin as a host would.
// Toggles while run is high, idles recessive high otherwise.
`default_nettype none
module swc_peer (
    input  wire logic clk,
    input  wire logic run,
    output var  logic can_tx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial can_tx_pin = 1'b1;
    always @(negedge clk) can_tx_pin <= run ? ~can_tx_pin : 1'b1;
endmodule // swc_peer
`default_nettype wire

// file: verif/can_selective_wake_control_bench.sv
// Self-checking bench for swc_ctrl with a pin peer.
// Assumes the design files under src/ are compiled first.
`default_nettype none
module can_selective_wake_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, restart = 0, reg_wr = 0, reg_rd = 0, stop_mode = 0, rdv = 0;
    logic wake_event = 0, wake_cfg_write = 0, transceiver_wake_mode = 0;
    logic bus_timeout_event = 0, run = 0, can_tx_pin, selective_wake_enable, osc_calibration_mode_enable;
    logic osc_sync_pulse, bus_timeout_flag, bus_timeout_irq;
    logic [6:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, quanta_per_bit, low_power_rx_option, q[$];
    logic [1:0] osc_clock_select = 0, quantum_clock_select;
    logic [31:0] s = 32'h6b0f3f2c;
    int n_errors = 0, checked = 0, i;
    swc_ctrl u_swc_ctrl (.*);
    swc_peer u_swc_peer (.*);
    always #5 clk = ~clk;
    function automatic logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input logic [7:0] v, e);
        checked++;
        if (v !== e) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk) reg_wr = 0;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
        q.push_back(e);
        @(negedge clk) reg_rd = 0;
    endtask
    task test_done;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Read data lands one edge after the strobe, so it is taken at the next falling edge.
    always @(posedge clk) rdv <= reg_rd;
    always @(negedge clk) if (rdv) chk(reg_rdata, q.pop_front());
    initial begin
        repeat (20) @(negedge clk);
        reset = 0;
        rd(7'h21, 8'ha0);
        rd(7'h20, 8'h00);
        wr(7'h20, 8'h01);
        @(negedge clk) chk(8'(selective_wake_enable), 8'h01);
        wr(7'h20, 8'hff);
        rd(7'h20, 8'hf1);
        chk(8'(osc_calibration_mode_enable), 8'h01);
        run = 1;
        for (i = 0; i < 9 && osc_sync_pulse !== 1'b1; i++) @(negedge clk);
        chk(8'(i < 9), 8'h01);
        if (i == 9) test_done;
        run = 0;
        s = lf(s);
        wr(7'h2f, s[7:0]);
        rd(7'h2f, s[7:0]);
        chk(low_power_rx_option, s[7:0]);
        wr(7'h20, 8'h91);
        wr(7'h2f, ~s[7:0]);
        rd(7'h2f, s[7:0]);
        chk(8'(osc_calibration_mode_enable), 8'h00);
        for (i = 0; i < 4; i++) begin
            s = lf(s);
            osc_clock_select = s[9:8];
            wr(7'h21, s[7:0]);
            rd(7'h21, s[7:0]);
            chk(8'(quantum_clock_select), 8'(s[9:8]));
            chk(quanta_per_bit, s[7:0]);
        end
        wr(7'h20, 8'h91);
        @(negedge clk) restart = 1;
        @(negedge clk) restart = 0;
        rd(7'h20, 8'h90);
        rd(7'h21, s[7:0]);
        for (i = 0; i < 2; i++) begin
            wr(7'h20, 8'h01);
            @(negedge clk) {wake_cfg_write, wake_event} = 2'(i + 1);
            @(negedge clk) {wake_cfg_write, wake_event} = 2'h0;
            @(negedge clk) chk(8'(selective_wake_enable), 8'h00);
        end
        stop_mode = 1;
        wr(7'h20, 8'h01);
        rd(7'h20, 8'h00);
        stop_mode = 0;
        wr(7'h20, 8'h10);
        {transceiver_wake_mode, bus_timeout_event} = 2'h3;
        repeat (2) @(negedge clk);
        chk(8'(bus_timeout_irq), 8'h01);
        {transceiver_wake_mode, bus_timeout_event} = 2'h0;
        repeat (2) @(negedge clk);
        chk(8'(bus_timeout_flag), 8'h01);
        wr(7'h20, 8'h00);
        {transceiver_wake_mode, bus_timeout_event} = 2'h3;
        repeat (2) @(negedge clk);
        chk(8'(bus_timeout_irq), 8'h00);
        {transceiver_wake_mode, bus_timeout_event} = 2'h0;
        rd(7'h7f, 8'h00);
        repeat (2) @(negedge clk);
        test_done;
    end
endmodule // can_selective_wake_control_bench
bind swc_ctrl swc_chk u_swc_chk (.*);
`default_nettype wire
